// ---- design/pin_sync.v ----
`timescale 1ns/1ps

// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module pin_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Asynchronous inputs and synchronised outputs
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

// ---- design/spi_port.v ----
`timescale 1ns/1ps
`include "spi_port_map.vh"

module spi_port (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Software accesses
    input wire ctrl_wr,
    input wire [7:0] ctrl_wdata,
    input wire csr_rd,
    input wire csr_wr,
    input wire [2:0] csr_wdata,
    input wire data_rd,
    input wire data_wr,
    input wire [7:0] data_wdata,
    input wire cpu_irq_mask,
    // Register contents
    output reg [7:0] port_control_q,
    output reg [2:0] soft_bits_q,
    output reg transfer_done_q,
    output reg write_collision_q,
    output reg overrun_q,
    output reg mode_fault_q,
    output reg [7:0] rx_data_q,
    output reg irq_q,
    // Serial clock pin
    input wire sck_in,
    output reg sck_out_q,
    output reg sck_oe_q,
    // Master out, slave in pin
    input wire mosi_in,
    output reg mosi_out_q,
    output reg mosi_oe_q,
    // Master in, slave out pin
    input wire miso_in,
    output reg miso_out_q,
    output reg miso_oe_q,
    // Slave select pin
    input wire ss_n_in
);

    // ****************************************
    // Rate decode
    // ****************************************
    function [6:0] half_period;
        input [2:0] code;
        begin
            case (code)
                `RATE_DIV4: half_period = `HALF_DIV4;
                `RATE_DIV8: half_period = `HALF_DIV8;
                `RATE_DIV16: half_period = `HALF_DIV16;
                `RATE_DIV32: half_period = `HALF_DIV32;
                `RATE_DIV64: half_period = `HALF_DIV64;
                default: half_period = `HALF_DIV128;
            endcase
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire sck_s;
    wire mosi_s;
    wire miso_s;
    wire ss_n_s;

    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk(ref_clk),
        .reset_n(reset_n),
        .din({sck_in, mosi_in, miso_in, ss_n_in}),
        .dout({sck_s, mosi_s, miso_s, ss_n_s})
    );

    // ****************************************
    // State
    // ****************************************
    reg [7:0] shift_q;
    reg cap_q;
    reg [3:0] edge_cnt_q;
    reg [6:0] half_cnt_q;
    reg busy_q;
    reg sck_prev_q;
    reg done_arm_q;
    reg fault_arm_q;
    reg coll_arm_q;

    wire irq_en = port_control_q[`CTRL_IRQ_EN];
    wire port_en = port_control_q[`CTRL_PORT_EN];
    wire master = port_control_q[`CTRL_MASTER];
    wire idle_level = port_control_q[`CTRL_IDLE_LEVEL];
    wire cap_second = port_control_q[`CTRL_CAPTURE_EDGE];
    wire [2:0] rate_code = {port_control_q[`CTRL_RATE2], port_control_q[`CTRL_RATE1],
        port_control_q[`CTRL_RATE0]};
    wire out_disable = soft_bits_q[`SOFT_OUT_DISABLE];

    wire ss_high = soft_bits_q[`SOFT_SELECT_MGMT] ? soft_bits_q[`SOFT_SELECT_LEVEL] : ss_n_s;

    wire master_act = port_en & master;
    wire slave_act = port_en & ~master & ~ss_high;

    wire fault_evt = master & ~ss_high;

    wire [6:0] half_len = half_period(rate_code);
    wire tick = busy_q & (half_cnt_q == half_len - 7'h01);

    wire slave_edge = slave_act & (sck_s != sck_prev_q);

    wire edge_now = master_act ? tick : slave_edge;
    wire in_bit = master ? miso_s : mosi_s;

    // capture on first or second edge
    wire capture_edge = (edge_cnt_q[0] == cap_second);
    wire shift_edge = ~capture_edge & ~(cap_second & (edge_cnt_q == 4'h0));
    wire last_edge = edge_now & (edge_cnt_q == `EDGE_LAST);
    wire [7:0] done_byte = cap_second ? {shift_q[6:0], in_bit} : {shift_q[6:0], cap_q};

    wire slave_busy = slave_act & (~cap_second | (edge_cnt_q != 4'h0));
    wire xfer_busy = busy_q | slave_busy;

    wire wr_blocked = transfer_done_q & ~done_arm_q;
    wire wr_ok = data_wr & ~xfer_busy & ~wr_blocked;
    wire wr_coll = data_wr & xfer_busy;

    wire done_clr = done_arm_q & (data_rd | (~master & data_wr));

    // ****************************************
    // Shift engine
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 8'h00;
            cap_q <= 1'b0;
            edge_cnt_q <= 4'h0;
            half_cnt_q <= 7'h00;
            busy_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            if (fault_evt || !port_en) begin
                busy_q <= 1'b0;
                edge_cnt_q <= 4'h0;
                half_cnt_q <= 7'h00;
                if (wr_ok) begin
                    shift_q <= data_wdata;
                end
            end else if (wr_ok) begin
                shift_q <= data_wdata;
                edge_cnt_q <= 4'h0;
                half_cnt_q <= 7'h00;
                busy_q <= master_act;
            end else begin
                if (busy_q) begin
                    half_cnt_q <= tick ? 7'h00 : half_cnt_q + 7'h01;
                end
                if (!master && ss_high) begin
                    edge_cnt_q <= 4'h0;
                end else if (edge_now) begin
                    // slave byte begins at first edge with second-edge capture, at select with first-edge capture
                    edge_cnt_q <= edge_cnt_q + 4'h1;
                    if (capture_edge) begin
                        cap_q <= in_bit;
                    end
                    if (shift_edge) begin
                        shift_q <= {shift_q[6:0], cap_q};
                    end
                    if (last_edge) begin
                        shift_q <= done_byte;
                        busy_q <= 1'b0;
                    end
                end
            end
        end
    end

    // ****************************************
    // Control and soft select bits
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_control_q <= `CTRL_RESET;
            soft_bits_q <= `SOFT_RESET;
        end else begin
            if (csr_wr) begin
                soft_bits_q <= csr_wdata;
            end
            if (fault_evt) begin
                port_control_q[`CTRL_PORT_EN] <= 1'b0;
                port_control_q[`CTRL_MASTER] <= 1'b0;
                if (ctrl_wr) begin
                    port_control_q[`CTRL_IRQ_EN] <= ctrl_wdata[`CTRL_IRQ_EN];
                    port_control_q[`CTRL_RATE2] <= ctrl_wdata[`CTRL_RATE2];
                    port_control_q[3:0] <= ctrl_wdata[3:0];
                end
            end else if (ctrl_wr) begin
                port_control_q <= ctrl_wdata;
                if (mode_fault_q && !fault_arm_q) begin
                    port_control_q[`CTRL_PORT_EN] <= 1'b0;
                    port_control_q[`CTRL_MASTER] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Status flags and receive buffer
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            transfer_done_q <= 1'b0;
            overrun_q <= 1'b0;
            write_collision_q <= 1'b0;
            mode_fault_q <= 1'b0;
            rx_data_q <= 8'h00;
            done_arm_q <= 1'b0;
            fault_arm_q <= 1'b0;
            coll_arm_q <= 1'b0;
        end else begin
            if (transfer_done_q && (csr_rd || csr_wr)) begin
                done_arm_q <= 1'b1;
            end
            if (mode_fault_q && csr_rd) begin
                fault_arm_q <= 1'b1;
            end
            if (write_collision_q && csr_rd) begin
                coll_arm_q <= 1'b1;
            end

            if (done_clr) begin
                transfer_done_q <= 1'b0;
                done_arm_q <= 1'b0;
            end
            if (last_edge) begin
                transfer_done_q <= 1'b1;
                if (!transfer_done_q || done_clr) begin
                    rx_data_q <= done_byte;
                    done_arm_q <= 1'b0;
                end
            end

            if (csr_rd) begin
                overrun_q <= 1'b0;
            end
            if (last_edge && transfer_done_q && !done_clr) begin
                overrun_q <= 1'b1;
            end

            if (coll_arm_q && (data_rd || data_wr)) begin
                write_collision_q <= 1'b0;
                coll_arm_q <= 1'b0;
            end
            if (wr_coll) begin
                write_collision_q <= 1'b1;
            end

            if (fault_arm_q && ctrl_wr) begin
                mode_fault_q <= 1'b0;
                fault_arm_q <= 1'b0;
            end
            if (fault_evt) begin
                mode_fault_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupt and pin drivers
    // ****************************************
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
            sck_out_q <= 1'b0;
            sck_oe_q <= 1'b0;
            mosi_out_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_out_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            // interrupt request, gated by CPU mask
            irq_q <= irq_en & ~cpu_irq_mask & (transfer_done_q | mode_fault_q | overrun_q);
            // master SCK toggles on each tick
            if (master_act && busy_q && !fault_evt) begin
                sck_out_q <= tick ? ~sck_out_q : sck_out_q;
            end else begin
                sck_out_q <= idle_level;
            end
            sck_oe_q <= master_act & ~fault_evt;
            mosi_out_q <= shift_q[7];
            mosi_oe_q <= master_act & ~fault_evt & ~out_disable;
            miso_out_q <= shift_q[7];
            miso_oe_q <= slave_act & ~out_disable;
        end
    end

endmodule

// ---- design/spi_port_map.vh ----
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// ****************************************
// Control register field positions
// ****************************************
`define CTRL_IRQ_EN 7
`define CTRL_PORT_EN 6
`define CTRL_RATE2 5
`define CTRL_MASTER 4
`define CTRL_IDLE_LEVEL 3
`define CTRL_CAPTURE_EDGE 2
`define CTRL_RATE1 1
`define CTRL_RATE0 0
`define CTRL_RESET 8'h00

// ****************************************
// Soft bits of the control/status register
// ****************************************
`define SOFT_OUT_DISABLE 2
`define SOFT_SELECT_MGMT 1
`define SOFT_SELECT_LEVEL 0
`define SOFT_RESET 3'h0

// ****************************************
// Clock rate field codes {rate2, rate1, rate0}
// ****************************************
`define RATE_DIV4 3'h4
`define RATE_DIV8 3'h0
`define RATE_DIV16 3'h1
`define RATE_DIV32 3'h6
`define RATE_DIV64 3'h2
`define RATE_DIV128 3'h3

// ****************************************
// Half periods of SCK in CPU clocks
// ****************************************
`define HALF_DIV4 7'h02
`define HALF_DIV8 7'h04
`define HALF_DIV16 7'h08
`define HALF_DIV32 7'h10
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40

// ****************************************
// Byte framing
// ****************************************
`define EDGE_LAST 4'hF

`endif

// ---- tb/spi_far_end.sv ----
`timescale 1ns/1ps
module spi_far_end (
    // Wire levels
    input wire sck_w,
    input wire mosi_w,
    input wire miso_w,
    // Far end drive
    output reg sck_o,
    output reg mosi_o,
    output reg ss_n_o,
    output wire miso_o
);
// ****
// Slave role, mode 0, and master role
// ****
reg slave_role = 1'b0;
reg [7:0] tx_s = 8'h00;
reg [7:0] rx_s = 8'h00;
integer n_edges = 0;
initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
end
// Released MISO keeps changing so a stale value is never seen
assign miso_o = slave_role ? tx_s[7] : ~mosi_o;
task load(input [7:0] b);
    begin
        tx_s = b;
        n_edges = 0;
    end
endtask
always @(posedge sck_w) if (slave_role) rx_s <= {rx_s[6:0], mosi_w};
always @(negedge sck_w) if (slave_role) tx_s <= {tx_s[6:0], 1'b0};
always @(sck_w) if (slave_role) n_edges = n_edges + 1;
task xfer(input [7:0] tx, input clock_idle_level_bit, input capture_edge_bit, output [7:0] rx);
    integer i;
    begin
        sck_o = clock_idle_level_bit;
        ss_n_o = 1'b0;
        rx = 8'h00;
        #320;
        for (i = 7; i >= 0; i = i - 1) begin
            if (capture_edge_bit) sck_o = ~clock_idle_level_bit;
            mosi_o = tx[i];
            // Sample at the capture edge, before the slave moves on
            #160 rx[i] = miso_w;
            sck_o = capture_edge_bit ? clock_idle_level_bit : ~clock_idle_level_bit;
            #160 if (!capture_edge_bit) sck_o = clock_idle_level_bit;
        end
        #160 mosi_o = ~mosi_o;
        // select up between bytes only with first-edge capture
        if (!capture_edge_bit) ss_n_o = 1'b1;
        #320;
    end
endtask
endmodule

// ---- tb/spi_port_sva.sv ----
`timescale 1ns/1ps
module spi_port_sva (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Software strobes
    input wire ctrl_wr,
    input wire csr_rd,
    input wire data_rd,
    input wire cpu_irq_mask,
    // Register contents
    input wire [7:0] port_control_q,
    input wire transfer_done_q,
    input wire write_collision_q,
    input wire overrun_q,
    input wire mode_fault_q,
    input wire irq_q,
    // Serial clock pin
    input wire sck_out_q,
    input wire sck_oe_q
);
// ****
// Clear sequence tracking
// ****
reg done_arm_q;
reg fault_arm_q;
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        done_arm_q <= 1'b0;
        fault_arm_q <= 1'b0;
    end else begin
        done_arm_q <= transfer_done_q & (done_arm_q | csr_rd);
        fault_arm_q <= mode_fault_q & (fault_arm_q | csr_rd);
    end
end
default clocking @(posedge ref_clk); endclocking
default disable iff (!reset_n);
a_done_clear: assert property (
    transfer_done_q && done_arm_q && data_rd && port_control_q[4] |=> !transfer_done_q) else $error("done not cleared");
a_fault_drops_mode: assert property (
    $rose(mode_fault_q) |-> ##[0:1] (!port_control_q[6] && !port_control_q[4] && !sck_oe_q)) else $error("fault kept mode");
a_fault_blocks: assert property (
    mode_fault_q && !fault_arm_q && !csr_rd && ctrl_wr |=> !port_control_q[6] && !port_control_q[4]) else $error("fault not blocking");
a_irq_cause: assert property (
    irq_q == $past(port_control_q[7] && !cpu_irq_mask && (transfer_done_q || overrun_q || mode_fault_q)))
    else $error("irq level wrong");
a_idle_after_byte: assert property (
    $rose(transfer_done_q) && port_control_q[4] |-> sck_out_q == port_control_q[3]) else $error("sck not idle");
a_ovr_needs_done: assert property (
    $rose(overrun_q) |-> $past(transfer_done_q)) else $error("overrun without done");
a_ovr_clear: assert property (
    overrun_q && csr_rd |=> !overrun_q) else $error("overrun not cleared");
a_write_collision_flag_no_irq: assert property (
    $rose(write_collision_q) && !transfer_done_q && !overrun_q && !mode_fault_q |=> !irq_q) else $error("collision irq");
endmodule

bind spi_port spi_port_sva chk (.ref_clk(ref_clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr), .csr_rd(csr_rd),
    .data_rd(data_rd), .cpu_irq_mask(cpu_irq_mask), .port_control_q(port_control_q),
    .transfer_done_q(transfer_done_q), .write_collision_q(write_collision_q), .overrun_q(overrun_q),
    .mode_fault_q(mode_fault_q), .irq_q(irq_q), .sck_out_q(sck_out_q), .sck_oe_q(sck_oe_q));

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
reg ref_clk, reset_n, ctrl_wr, csr_rd, csr_wr, data_rd, data_wr, cpu_irq_mask;
reg [7:0] ctrl_wdata, data_wdata, got;
reg [2:0] csr_wdata;
wire [7:0] port_control_q, rx_data_q;
wire [2:0] soft_bits_q;
wire transfer_done_q, write_collision_q, overrun_q, mode_fault_q, irq_q;
wire sck_out_q, sck_oe_q, mosi_out_q, mosi_oe_q, miso_out_q, miso_oe_q, sck_f, mosi_f, miso_f, ss_f;
wire sck_w = sck_oe_q ? sck_out_q : sck_f;
wire mosi_w = mosi_oe_q ? mosi_out_q : mosi_f;
wire miso_w = miso_oe_q ? miso_out_q : miso_f;
integer n_fail = 0, total_checks = 0, i, m;
spi_port DUT (.ref_clk(ref_clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .cpu_irq_mask(cpu_irq_mask), .port_control_q(port_control_q),
    .soft_bits_q(soft_bits_q), .transfer_done_q(transfer_done_q), .write_collision_q(write_collision_q),
    .overrun_q(overrun_q), .mode_fault_q(mode_fault_q), .rx_data_q(rx_data_q), .irq_q(irq_q),
    .sck_in(sck_w), .sck_out_q(sck_out_q), .sck_oe_q(sck_oe_q), .mosi_in(mosi_w), .mosi_out_q(mosi_out_q),
    .mosi_oe_q(mosi_oe_q), .miso_in(miso_w), .miso_out_q(miso_out_q), .miso_oe_q(miso_oe_q), .ss_n_in(ss_f));
spi_far_end far (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .sck_o(sck_f), .mosi_o(mosi_f),
    .ss_n_o(ss_f), .miso_o(miso_f));
// ****
// Clock, checks and access tasks
// ****
initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
end
task check(input string name, input [7:0] seen, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    end
endtask
task flag(input string name, input seen, input exp);
    check(name, {7'h00, seen}, {7'h00, exp});
endtask
task idle(input integer n);
    repeat (n) @(negedge ref_clk);
endtask
// Op 0 control write, 1 soft bits write, 2 status read, 3 data read, 4 data write
task acc(input integer op, input [7:0] v);
    begin
        @(negedge ref_clk);
        ctrl_wdata = v;
        csr_wdata = v[2:0];
        data_wdata = v;
        {data_wr, data_rd, csr_rd, csr_wr, ctrl_wr} = 5'h01 << op;
        @(negedge ref_clk);
        {data_wr, data_rd, csr_rd, csr_wr, ctrl_wr} = 5'h00;
        idle(1);
    end
endtask
task wait_bit(input integer w);
    begin
        i = 0;
        while (i < 600 && (w ? overrun_q : transfer_done_q) !== 1'b1) begin
            @(negedge ref_clk);
            i = i + 1;
        end
        idle(2);
    end
endtask
task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end
endtask
initial begin
    #400000;
    n_fail = n_fail + 1;
    tally_and_finish;
end
// ****
// Tests
// ****
initial begin
    reset_n = 1'b0;
    {data_wr, data_rd, csr_rd, csr_wr, ctrl_wr, cpu_irq_mask} = 6'h00;
    {ctrl_wdata, data_wdata, csr_wdata} = 19'h00000;
    idle(12);
    reset_n = 1'b1;
    idle(2);
    check("control", port_control_q, 8'h00);
    flag("sck oe", sck_oe_q, 1'b0);
    far.slave_role = 1'b1;
    far.load(8'h3C);
    acc(1, 8'h03);
    acc(0, 8'hD1);
    check("edges", far.n_edges[7:0], 8'h00);
    acc(4, 8'hA5);
    acc(4, 8'h11);
    flag("write_collision_flag", write_collision_q, 1'b1);
    wait_bit(0);
    check("mosi", far.rx_s, 8'hA5);
    check("edges", far.n_edges[7:0], 8'h10);
    check("rx", rx_data_q, 8'h3C);
    flag("irq", irq_q, 1'b1);
    cpu_irq_mask = 1'b1;
    idle(2);
    flag("irq", irq_q, 1'b0);
    cpu_irq_mask = 1'b0;
    acc(3, 8'h00);
    flag("done", transfer_done_q, 1'b1);
    acc(4, 8'h22);
    idle(40);
    check("edges", far.n_edges[7:0], 8'h10);
    acc(2, 8'h00);
    acc(3, 8'h00);
    flag("done", transfer_done_q, 1'b0);
    flag("write_collision_flag", write_collision_q, 1'b0);
    $display("test master done");
    far.load(8'hC3);
    acc(4, 8'h81);
    wait_bit(0);
    check("cycles", i[7:0], 8'h7F);
    check("rx", rx_data_q, 8'hC3);
    acc(2, 8'h00);
    far.load(8'h99);
    acc(4, 8'h7E);
    wait_bit(1);
    flag("ovr", overrun_q, 1'b1);
    check("rx", rx_data_q, 8'hC3);
    flag("done", transfer_done_q, 1'b1);
    acc(2, 8'h00);
    flag("ovr", overrun_q, 1'b0);
    acc(3, 8'h00);
    flag("done", transfer_done_q, 1'b0);
    $display("test overrun done");
    acc(1, 8'h02);
    idle(1);
    flag("fault", mode_fault_q, 1'b1);
    check("control", port_control_q, 8'h81);
    flag("sck oe", sck_oe_q, 1'b0);
    flag("irq", irq_q, 1'b1);
    acc(0, 8'hD1);
    check("control", port_control_q, 8'h81);
    acc(1, 8'h03);
    acc(2, 8'h00);
    acc(0, 8'hD1);
    flag("fault", mode_fault_q, 1'b0);
    check("control", port_control_q, 8'hD1);
    flag("mosi oe", mosi_oe_q, 1'b1);
    acc(1, 8'h07);
    flag("mosi oe", mosi_oe_q, 1'b0);
    check("soft", {5'h00, soft_bits_q}, 8'h07);
    $display("test fault done");
    far.slave_role = 1'b0;
    acc(1, 8'h00);
    for (m = 0; m < 4; m = m + 1) begin
        far.ss_n_o = 1'b1;
        acc(0, 8'h00);
        far.sck_o = m[1];
        acc(0, {4'h4, m[1:0], 2'b00});
        acc(4, 8'hC0 | m[7:0]);
        flag("done", transfer_done_q, 1'b0);
        far.xfer(8'h5A ^ m[7:0], m[1], m[0], got);
        idle(4);
        check("miso", got, 8'hC0 | m[7:0]);
        check("rx", rx_data_q, 8'h5A ^ m[7:0]);
        flag("done", transfer_done_q, 1'b1);
        acc(2, 8'h00);
    end
    acc(3, 8'h00);
    flag("done", transfer_done_q, 1'b0);
    $display("test slave done");
    tally_and_finish;
end
endmodule
